// File: rtl/seep_core.sv
// Serial EEPROM command front end: decoder, latch, status, protection, array
// Functional notes
// - Byte addressed array of 1024 or 2048 bytes
// - Opcode shifts into 8-bit register on rising SCK
// - All fields travel MSB first
// - First bit taken on first rise after select
// - Output changes after falling edge, inputs on rise
// - Write latch gates every internal write
// - Latch clears at reset and when a write cycle starts
// - Decode latch set, latch clear, status read
// - Decode status write, array read, array write
// - Status read answers even while busy
// - Status bit 0 shows write in progress
// - Status bit 1 mirrors latch; clear refuses writes
// - Latch opcodes work regardless of write protection
// - Block protect bits change only by status write
// - Block protect decode none, quarter, half, all
// - Protected blocks never written
// - Low protect pin with enable bit locks status
// - Sixteen-bit address, upper bits ignored
// - Read pointer increments after each byte
// - Read address wraps from top to zero
// - Deselect stops output
// - Hold pauses sequence without losing state
// - Page write wraps within sixteen-byte page
// - Write starts only on byte-aligned deselect
// - Array ignored during internal write
`timescale 1ns/10ps
module seep_core #(
    parameter int BYTES   = seep_pkg::SEEP_BYTES_DEF,
    parameter int TWC_CYC = seep_pkg::SEEP_TWC_CYC
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire seep_pkg::seep_pins_t pins,
    output logic                  so_o,
    output logic                  so_oe,
    output logic [7:0]            device_status
);
    import seep_pkg::*;

    localparam int AW = $clog2(BYTES);
    localparam int PW = $clog2(SEEP_PAGE_BYTES);

    // Synthesised array; nonvolatile in the real part, so no reset
    logic [7:0]    mem [BYTES];
    logic [7:0]    page_buf [SEEP_PAGE_BYTES];
    logic [SEEP_PAGE_BYTES-1:0] page_vld_r;

    logic          sck_d_r;
    logic          cs_n_d_r;
    logic          hold_act_r;
    seep_phase_t   phase_r;
    logic [2:0]    bit_r;
    logic [7:0]    shin_r;
    logic [7:0]    shout_r;
    logic [AW-1:0] addr_r;
    logic [7:0]    addr_hi_r;
    logic          is_write_r;
    logic          latch_r;
    logic          latch_set_pend_r;
    logic          latch_clr_pend_r;
    logic          arm_r;
    logic          stat_arm_r;
    logic [7:0]    stat_new_r;
    logic [7:0]    nv_r;
    logic          busy_r;
    logic          busy_stat_r;
    logic [$clog2(TWC_CYC+1)-1:0] twc_r;
    logic [AW-1:0] pg_base_r;

    // Edge detection on the oversampled SCK; idle level is irrelevant
    wire sck_rise   = pins.sck & ~sck_d_r;
    wire sck_fall   = ~pins.sck & sck_d_r;
    wire selected   = ~pins.cs_n;
    wire cs_rise    = pins.cs_n & ~cs_n_d_r;
    // Hold only takes or leaves effect while SCK is low
    wire hold_nxt   = (~pins.sck) ? ~pins.hold_n : hold_act_r;
    wire active     = selected & ~hold_act_r;
    wire take_bit   = active & sck_rise;
    wire [7:0] byte_in = {shin_r[6:0], pins.si};
    wire byte_done  = take_bit & (bit_r == SEEP_BIT_LAST);
    wire [AW-1:0] full_addr = AW'({addr_hi_r, byte_in});

    // Block protect decode: fraction of the top of the array
    wire [1:0] bp = {nv_r[SEEP_BIT_BP_HI], nv_r[SEEP_BIT_BP_LO]};
    wire [1:0] top2 = addr_r[AW-1 -: 2];
    wire prot_hit = (bp == 2'h3) | ((bp == 2'h2) & top2[1])
                  | ((bp == 2'h1) & (top2 == 2'h3));
    // Hardware protection covers only the status bits
    wire hw_prot = ~pins.wp_n & nv_r[SEEP_BIT_PEN];

    wire [7:0] status_now = {nv_r[7:2], latch_r, busy_r};
    wire [7:0] next_rd    = mem[addr_r];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sck_d_r  <= 1'b0;
            cs_n_d_r <= 1'b1;
            hold_act_r <= 1'b0;
        end else begin
            sck_d_r  <= pins.sck;
            cs_n_d_r <= pins.cs_n;
            hold_act_r <= selected & hold_nxt;
        end
    end

    // Serial sequencer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase_r          <= SEEP_OPC;
            bit_r            <= SEEP_BIT_ZERO;
            shin_r           <= 8'h00;
            addr_r           <= '0;
            addr_hi_r        <= 8'h00;
            is_write_r       <= 1'b0;
            latch_set_pend_r <= 1'b0;
            latch_clr_pend_r <= 1'b0;
            arm_r            <= 1'b0;
            stat_arm_r       <= 1'b0;
            stat_new_r       <= 8'h00;
            page_vld_r       <= '0;
            pg_base_r        <= '0;
        end else if (!selected) begin
            phase_r          <= SEEP_OPC;
            bit_r            <= SEEP_BIT_ZERO;
            latch_set_pend_r <= 1'b0;
            latch_clr_pend_r <= 1'b0;
            arm_r            <= 1'b0;
            stat_arm_r       <= 1'b0;
            page_vld_r       <= '0;
        end else if (take_bit) begin
            bit_r  <= bit_r + 3'h1;
            shin_r <= byte_in;
            // Any extra bit disarms pending actions until the byte closes
            if (bit_r == SEEP_BIT_ZERO) begin
                arm_r            <= 1'b0;
                stat_arm_r       <= 1'b0;
                latch_set_pend_r <= 1'b0;
                latch_clr_pend_r <= 1'b0;
            end
            if (byte_done) begin
                unique case (phase_r)
                    SEEP_OPC: begin
                        latch_set_pend_r <= (byte_in == SEEP_OP_LATCH_SET);
                        latch_clr_pend_r <= (byte_in == SEEP_OP_LATCH_CLR);
                        is_write_r <= (byte_in == SEEP_OP_ARR_WR);
                        if (byte_in == SEEP_OP_STAT_RD)
                            phase_r <= SEEP_STAT_OUT;
                        else if (byte_in == SEEP_OP_STAT_WR)
                            phase_r <= SEEP_STAT_IN;
                        else if ((byte_in == SEEP_OP_ARR_RD || byte_in == SEEP_OP_ARR_WR)
                                 && !busy_r)
                            phase_r <= SEEP_ADDR_HI;
                        else
                            phase_r <= SEEP_IGNORE;
                    end
                    SEEP_ADDR_HI: begin
                        addr_hi_r <= byte_in;
                        phase_r   <= SEEP_ADDR_LO;
                    end
                    SEEP_ADDR_LO: begin
                        addr_r    <= full_addr;
                        pg_base_r <= full_addr;
                        phase_r   <= is_write_r ? SEEP_WR_DATA : SEEP_RD_DATA;
                    end
                    SEEP_RD_DATA: addr_r <= addr_r + AW'(1);
                    SEEP_WR_DATA: begin
                        page_buf[addr_r[PW-1:0]] <= byte_in;
                        page_vld_r[addr_r[PW-1:0]] <= 1'b1;
                        // Counter rolls within the page only
                        addr_r[PW-1:0] <= addr_r[PW-1:0] + PW'(1);
                        arm_r <= 1'b1;
                    end
                    SEEP_STAT_IN: begin
                        // Kept while busy so a refused write cannot alter the pending update
                        if (!busy_r)
                            stat_new_r <= byte_in;
                        stat_arm_r <= 1'b1;
                        phase_r    <= SEEP_IGNORE;
                    end
                    SEEP_STAT_OUT, SEEP_IGNORE: ;
                endcase
            end
        end
    end

    // Deselect outcomes: latch, status write, page commit
    wire wr_go   = cs_rise & arm_r & latch_r & ~busy_r;
    wire st_go   = cs_rise & stat_arm_r & latch_r & ~busy_r & ~hw_prot;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            latch_r     <= 1'b0;
            busy_r      <= 1'b0;
            busy_stat_r <= 1'b0;
            twc_r       <= '0;
            nv_r        <= 8'h00;
        end else begin
            if (cs_rise && latch_set_pend_r)
                latch_r <= 1'b1;
            else if (cs_rise && latch_clr_pend_r)
                latch_r <= 1'b0;
            else if (wr_go || st_go)
                latch_r <= 1'b0;
            if (wr_go || st_go) begin
                busy_r      <= 1'b1;
                busy_stat_r <= st_go;
                twc_r       <= '0;
            end else if (busy_r) begin
                if (twc_r == ($bits(twc_r))'(TWC_CYC - 1)) begin
                    busy_r <= 1'b0;
                    busy_stat_r <= 1'b0;
                    if (busy_stat_r)
                        nv_r <= (nv_r & ~SEEP_STAT_WR_MASK)
                              | (stat_new_r & SEEP_STAT_WR_MASK);
                end else begin
                    twc_r <= twc_r + 1'b1;
                end
            end
        end
    end

    // Commit the loaded page bytes at the end of the cycle, skipping protected ones
    wire commit = busy_r & ~busy_stat_r & (twc_r == ($bits(twc_r))'(TWC_CYC - 1));
    logic [SEEP_PAGE_BYTES-1:0] prot_pg_r;
    wire  [1:0] pg_top2 = pg_base_r[AW-1 -: 2];
    wire  pg_prot = (bp == 2'h3) | ((bp == 2'h2) & pg_top2[1])
                  | ((bp == 2'h1) & (pg_top2 == 2'h3));
    logic [SEEP_PAGE_BYTES-1:0] wr_mask_r;
    always_ff @(posedge clk) begin
        if (!reset_n)
            wr_mask_r <= '0;
        else if (wr_go)
            wr_mask_r <= pg_prot ? '0 : page_vld_r;
    end
    assign prot_pg_r = wr_mask_r;

    // One writer process for the array; the loop only builds per-byte enables
    logic [SEEP_PAGE_BYTES-1:0] commit_en;
    genvar g;
    generate
        for (g = 0; g < SEEP_PAGE_BYTES; g++) begin : g_commit
            assign commit_en[g] = commit & prot_pg_r[g];
        end
    endgenerate
    always_ff @(posedge clk) begin
        for (int i = 0; i < SEEP_PAGE_BYTES; i++) begin
            if (commit_en[i])
                mem[{pg_base_r[AW-1:PW], PW'(i)}] <= page_buf[i];
        end
    end

    // Output shifter, updated after the falling edge
    wire load_out = (phase_r == SEEP_STAT_OUT || phase_r == SEEP_RD_DATA);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shout_r <= 8'h00;
            so_o    <= 1'b0;
            so_oe   <= 1'b0;
            device_status <= 8'h00;
        end else begin
            device_status <= status_now;
            so_oe <= active & load_out;
            if (active && sck_fall && load_out) begin
                if (bit_r == SEEP_BIT_ZERO) begin
                    // Fresh byte each time the bit counter wraps
                    shout_r <= (phase_r == SEEP_STAT_OUT) ? status_now : next_rd;
                    so_o    <= (phase_r == SEEP_STAT_OUT) ? status_now[7] : next_rd[7];
                    if (phase_r == SEEP_STAT_OUT)
                        shout_r <= {status_now[6:0], 1'b0};
                    else
                        shout_r <= {next_rd[6:0], 1'b0};
                end else begin
                    so_o    <= shout_r[7];
                    shout_r <= {shout_r[6:0], 1'b0};
                end
            end
        end
    end

    AST_LATCH_NEEDS_DESELECT: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(latch_r) |-> $past(cs_rise) && $past(latch_set_pend_r))
        else $error("latch set without deselect after set opcode");
    AST_LATCH_CLR_ON_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_go || st_go) && !latch_set_pend_r |=> !latch_r)
        else $error("latch not cleared after write");
    AST_NO_WRITE_WITHOUT_LATCH: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(busy_r) |-> $past(latch_r))
        else $error("write started without latch");
    AST_BUSY_BIT: assert property (@(posedge clk) disable iff (!reset_n)
        device_status[SEEP_BIT_BUSY] == $past(busy_r))
        else $error("busy bit mismatch");
    AST_LATCH_BIT: assert property (@(posedge clk) disable iff (!reset_n)
        device_status[SEEP_BIT_LATCH] == $past(latch_r))
        else $error("latch bit mismatch");
    AST_STATUS_LOCK: assert property (@(posedge clk) disable iff (!reset_n)
        cs_rise && stat_arm_r && hw_prot && !busy_r |=> !busy_r)
        else $error("status write passed hardware protection");
    AST_SO_OFF_DESELECTED: assert property (@(posedge clk) disable iff (!reset_n)
        !selected |=> !so_oe)
        else $error("output enabled while deselected");
    AST_BP_STABLE: assert property (@(posedge clk) disable iff (!reset_n)
        !busy_stat_r |=> nv_r == $past(nv_r))
        else $error("protect bits changed outside status write");
    AST_ADDR_WRAP: assert property (@(posedge clk) disable iff (!reset_n)
        take_bit && byte_done && phase_r == SEEP_RD_DATA && &addr_r |=> addr_r == '0)
        else $error("read address did not wrap");

    // Building blocks for the command checks below
    sequence seq_opcode(logic [7:0] op);
        take_bit && byte_done && phase_r == SEEP_OPC && byte_in == op;
    endsequence
    sequence seq_set_frame;
        cs_rise && latch_set_pend_r;
    endsequence
    sequence seq_paused;
        hold_act_r && selected;
    endsequence

    AST_LATCH_SETS: assert property (@(posedge clk) disable iff (!reset_n)
        seq_set_frame |=> latch_r)
        else $error("latch not set after set opcode frame");
    AST_LATCH_CLEARS: assert property (@(posedge clk) disable iff (!reset_n)
        cs_rise && latch_clr_pend_r |=> !latch_r)
        else $error("latch not cleared after clear opcode frame");
    AST_STAT_RD_DECODE: assert property (@(posedge clk) disable iff (!reset_n)
        seq_opcode(SEEP_OP_STAT_RD) |=> phase_r == SEEP_STAT_OUT)
        else $error("status read opcode not decoded");
    AST_WR_IGNORED_BUSY: assert property (@(posedge clk) disable iff (!reset_n)
        seq_opcode(SEEP_OP_ARR_WR) ##0 busy_r |=> phase_r == SEEP_IGNORE)
        else $error("array write accepted during write cycle");
    AST_HOLD_FREEZE: assert property (@(posedge clk) disable iff (!reset_n)
        seq_paused |=> $stable(bit_r) && $stable(phase_r) && $stable(shout_r))
        else $error("sequence moved while paused");
    AST_PROT_PAGE: assert property (@(posedge clk) disable iff (!reset_n)
        wr_go && prot_hit |=> wr_mask_r == '0)
        else $error("protected page not masked");
    AST_WRITE_ALIGNED: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(busy_r) && !busy_stat_r |-> $past(arm_r))
        else $error("array write started without a complete byte");
    AST_BUSY_SPAN: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(busy_r) |-> $past(twc_r) == ($bits(twc_r))'(TWC_CYC - 1))
        else $error("write cycle ended early");
endmodule : seep_core

// File: rtl/seep_pkg.sv
// Constants and types for the serial EEPROM command front end
package seep_pkg;
    localparam int          SEEP_BYTES_DEF    = 1024;
    localparam logic [7:0]  SEEP_OP_LATCH_SET = 8'h06;
    localparam logic [7:0]  SEEP_OP_LATCH_CLR = 8'h04;
    localparam logic [7:0]  SEEP_OP_STAT_RD   = 8'h05;
    localparam logic [7:0]  SEEP_OP_STAT_WR   = 8'h01;
    localparam logic [7:0]  SEEP_OP_ARR_RD    = 8'h03;
    localparam logic [7:0]  SEEP_OP_ARR_WR    = 8'h02;
    localparam int          SEEP_BIT_BUSY     = 0;
    localparam int          SEEP_BIT_LATCH    = 1;
    localparam int          SEEP_BIT_BP_LO    = 2;
    localparam int          SEEP_BIT_BP_HI    = 3;
    localparam int          SEEP_BIT_PEN      = 7;
    localparam logic [7:0]  SEEP_STAT_WR_MASK = 8'h8C;
    localparam int          SEEP_PAGE_BYTES   = 16;
    localparam int          SEEP_CLK_MHZ      = 100;
    localparam int          SEEP_TWC_US       = 5000;
    localparam int          SEEP_TWC_CYC      = SEEP_TWC_US * SEEP_CLK_MHZ;
    localparam logic [2:0]  SEEP_BIT_LAST     = 3'h7;
    localparam logic [2:0]  SEEP_BIT_ZERO     = 3'h0;

    typedef enum logic [2:0] {
        SEEP_OPC, SEEP_ADDR_HI, SEEP_ADDR_LO, SEEP_RD_DATA, SEEP_WR_DATA,
        SEEP_STAT_OUT, SEEP_STAT_IN, SEEP_IGNORE
    } seep_phase_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } seep_pins_t;
endpackage : seep_pkg

// File: test/seep_spi_master.sv
// SPI master model that drives the serial EEPROM pins in mode 0 or mode 3
`timescale 1ns/10ps
module seep_spi_master #(
    parameter int HALF = 5
) (
    input  wire logic clk,
    input  wire logic so_o,
    input  wire logic so_oe,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    logic idle_hi;
    logic last_so;
    logic so_seen;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        idle_hi = 1'b0;
        last_so = 1'b0;
    end
    // A released output line reads as the inverse of its last value, so stale data never matches
    assign so_seen = so_oe ? so_o : ~last_so;
    always @(posedge clk) if (so_oe) last_so <= so_o;
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_clk
    task automatic select(input logic mode3);
        idle_hi = mode3;
        sck = mode3;
        wait_clk(HALF);
        cs_n = 1'b0;
        wait_clk(HALF);
    endtask : select
    // Hold is taken and released only while the clock is low
    task automatic xfer(input logic [7:0] tx, input int nb, input logic pause,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            sck = 1'b0;
            si = tx[i];
            wait_clk(HALF);
            if (pause && i == 4) begin
                hold_n = 1'b0;
                wait_clk(3 * HALF);
                hold_n = 1'b1;
                wait_clk(HALF);
            end
            rx[i] = so_seen;
            sck = 1'b1;
            wait_clk(HALF);
        end
    endtask : xfer
    task automatic deselect();
        if (!idle_hi) begin
            sck = 1'b0;
            wait_clk(HALF);
        end
        cs_n = 1'b1;
        si = ~si;
        wait_clk(4 * HALF);
    endtask : deselect
endmodule : seep_spi_master

// File: test/spi_serial_eeprom_core_tb.sv
// Self-checking bench for the serial EEPROM command front end
`timescale 1ns/10ps
module spi_serial_eeprom_core_tb;
    import seep_pkg::*;
    localparam int TWC = 600;
    logic       clk, reset_n, wp_n, so_o, so_oe, cs_n, sck, si, hold_n;
    logic [7:0] device_status, rx;
    logic [31:0] seed;
    logic [7:0] mem [1024];
    int         miscompares, total_checks;
    seep_pins_t pins;
    assign pins = '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};
    seep_core #(.BYTES(1024), .TWC_CYC(TWC)) dut (.clk(clk), .reset_n(reset_n), .pins(pins),
        .so_o(so_o), .so_oe(so_oe), .device_status(device_status));
    seep_spi_master m (.clk(clk), .so_o(so_o), .so_oe(so_oe), .cs_n(cs_n), .sck(sck),
        .si(si), .hold_n(hold_n));
    always #5 clk = ~clk;
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift
    function automatic int prot_q(input int bp);
        return (bp == 3) ? 4 : bp;
    endfunction : prot_q
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic op(input logic [7:0] opc);
        m.select(seed[0]);
        m.xfer(opc, 8, 1'b0, rx);
        m.deselect();
    endtask : op
    task automatic stat_rd();
        m.select(seed[1]);
        m.xfer(SEEP_OP_STAT_RD, 8, 1'b0, rx);
        m.xfer(8'h00, 8, 1'b0, rx);
        m.deselect();
    endtask : stat_rd
    // Bounded poll; leaves the last status in rx
    task automatic wait_idle();
        for (int k = 0; k < 8; k++) begin
            stat_rd();
            if (rx[SEEP_BIT_BUSY] === 1'b0) break;
        end
    endtask : wait_idle
    task automatic wstat(input logic [7:0] v);
        m.select(seed[2]);
        m.xfer(SEEP_OP_STAT_WR, 8, 1'b0, rx);
        m.xfer(v, 8, 1'b0, rx);
        m.deselect();
        wait_idle();
    endtask : wstat
    task automatic arr(input logic [7:0] opc, input logic [15:0] a, input int n, input int nb,
                       input logic ok);
        logic [7:0] d;
        logic [9:0] x;
        m.select(seed[3]);
        m.xfer(opc, 8, 1'b0, d);
        m.xfer(a[15:8], 8, 1'b0, d);
        m.xfer(a[7:0], 8, 1'b0, d);
        for (int i = 0; i < n; i++) begin
            d = 8'(xorshift());
            if (opc == SEEP_OP_ARR_WR) begin
                x = {a[9:4], 4'(a[3:0] + i)};
                m.xfer(d, (i == n - 1) ? nb : 8, 1'b0, rx);
                if (ok) mem[x] = d;
            end else begin
                x = 10'(a + i);
                m.xfer(8'h00, 8, d[0], rx);
                if (^mem[x] !== 1'bx) check("array", rx, mem[x]);
            end
        end
        m.deselect();
    endtask : arr
    initial begin
        // Worst case of the scenarios below is about 75k cycles
        repeat (95000) @(posedge clk);
        miscompares++;
        stop_test();
    end
    initial begin
        logic [15:0] a;
        clk = 1'b0;
        reset_n = 1'b0;
        wp_n = 1'b1;
        seed = 18;
        miscompares = 0;
        total_checks = 0;
        foreach (mem[i]) mem[i] = 'x;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        check("status_port", device_status, 8'h00);
        check("so_idle", {7'h00, so_oe}, 8'h00);
        op(SEEP_OP_LATCH_SET);
        check("status_port_latch", device_status, 8'h02);
        stat_rd();
        check("latch_set", rx, 8'h02);
        op(SEEP_OP_LATCH_CLR);
        stat_rd();
        check("latch_clr", rx, 8'h00);
        m.select(1'b0);
        m.xfer(SEEP_OP_LATCH_SET, 8, 1'b0, rx);
        m.xfer(SEEP_OP_ARR_WR, 8, 1'b0, rx);
        m.deselect();
        stat_rd();
        check("latch_kept_low", rx, 8'h00);
        arr(SEEP_OP_ARR_WR, 16'h0100, 2, 8, 1'b0);
        stat_rd();
        check("refused_idle", rx, 8'h00);
        for (int t = 0; t < 8; t++) begin
            a = (t == 0) ? 16'hA3FE : (t == 1) ? 16'h0000 : 16'(xorshift());
            op(SEEP_OP_LATCH_SET);
            arr(SEEP_OP_ARR_WR, a, (t < 2) ? 4 : 1 + xorshift() % 20, 8, 1'b1);
            stat_rd();
            check("busy", rx & 8'h01, 8'h01);
            op(SEEP_OP_LATCH_SET);
            arr(SEEP_OP_ARR_WR, a, 1, 8, 1'b0);
            op(SEEP_OP_LATCH_CLR);
            wait_idle();
            check("after_write", rx, 8'h00);
            arr(SEEP_OP_ARR_RD, {a[15:4], 4'h0}, 16, 8, 1'b0);
        end
        arr(SEEP_OP_ARR_RD, 16'h5FFE, 4, 8, 1'b0);
        for (int bp = 0; bp < 4; bp++) begin
            op(SEEP_OP_LATCH_SET);
            wstat(8'(bp << 2));
            check("block_bits", rx, 8'(bp << 2));
            for (int q = 0; q < 4; q++) begin
                op(SEEP_OP_LATCH_SET);
                arr(SEEP_OP_ARR_WR, 16'(q * 256 + 240), 2, 8, q < 4 - prot_q(bp));
                wait_idle();
                arr(SEEP_OP_ARR_RD, 16'(q * 256 + 240), 2, 8, 1'b0);
            end
        end
        op(SEEP_OP_LATCH_SET);
        wstat(8'h80);
        check("enable_bit", rx, 8'h80);
        op(SEEP_OP_LATCH_SET);
        arr(SEEP_OP_ARR_WR, 16'h00F0, 1, 5, 1'b0);
        stat_rd();
        check("abort_idle", rx & 8'h01, 8'h00);
        arr(SEEP_OP_ARR_RD, 16'h00F0, 2, 8, 1'b0);
        wp_n = 1'b0;
        op(SEEP_OP_LATCH_SET);
        wstat(8'h0C);
        check("pin_lock", rx & SEEP_STAT_WR_MASK, 8'h80);
        op(SEEP_OP_LATCH_CLR);
        stat_rd();
        check("latch_under_lock", rx, 8'h80);
        stop_test();
    end
endmodule : spi_serial_eeprom_core_tb
